// ### pwm_timer_channel_control.sv
// Purpose: control registers of one 16-bit pwm timer channel
// Assumes: source ticks are synchronous to aclk
// Notes: counter, comparators and pwm output live outside
//        ce low freezes every register and holds the readys low
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"
module pwm_timer_channel_control
  import pwm_timer_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [3:0] src_tick, // ticks of the four clock sources
  input wire logic [`ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  output logic count_tick, // gated divided count clock tick
  output logic counter_run, // counter runs
  output logic counter_reset_pulse, // one-cycle counter reset
  output logic one_shot_repeat_select, // 1 one-shot, 0 repeat
  output logic compare_buffer_enable, // buffered compare writes
  output logic multi_compare_capture_mode, // multi mode
  output logic [1:0] counter_channel_select, // counter select
  output logic [1:0] count_clock_source_select // clock source
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [`CLK_CTRL_W-1:0] clk_ctrl_r;
  logic [`CNT_CTRL_W-1:0] cnt_ctrl_r;
  logic crst_r;
  wr_state_t wr_state_r;
  logic aw_have_r;
  logic w_have_r;
  logic [`ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // one-hot register select from a byte address; shared by both paths
  function automatic logic [1:0] reg_sel(input logic [`ADDR_W-1:0] a);
    reg_sel = (a == `CLK_CTRL_ADDR) ? 2'b01 :
              (a == `CNT_CTRL_ADDR) ? 2'b10 : 2'b00;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  // a half that arrives alone is parked until its partner is offered
  // a write with no strobe on a lane leaves that lane untouched
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_ok = aw_have_r || aw_take;
  wire w_ok = w_have_r || w_take;
  wire [`ADDR_W-1:0] wa = aw_have_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd = w_have_r ? w_data_r : s_axi_wdata;
  wire [3:0] ws = w_have_r ? w_strb_r : s_axi_wstrb;
  wire do_wr = ce && (wr_state_r == WR_IDLE) && aw_ok && w_ok;
  wire [1:0] wsel = reg_sel(wa);
  wire wr_clk = do_wr && wsel[0] && ws[0];
  wire wr_cnt_lo = do_wr && wsel[1] && ws[0];
  wire wr_cnt_hi = do_wr && wsel[1] && ws[1];

  assign s_axi_awready = ce && (wr_state_r == WR_IDLE) && !aw_have_r;
  assign s_axi_wready = ce && (wr_state_r == WR_IDLE) && !w_have_r;
  assign s_axi_bvalid = (wr_state_r == WR_RESP);
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= WR_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bresp_r <= `RESP_OKAY;
    end else if (ce) begin
      case (wr_state_r)
        WR_IDLE: begin
          if (do_wr) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bresp_r <= (wsel == 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
            wr_state_r <= WR_RESP;
          end else begin
            if (aw_take) begin
              aw_have_r <= 1'b1;
              aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
              w_have_r <= 1'b1;
              w_data_r <= s_axi_wdata;
              w_strb_r <= s_axi_wstrb;
            end
          end
        end
        // nothing new is taken while the response waits for bready
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= WR_IDLE;
          end
        end
        default: wr_state_r <= WR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers; all fields reset to zero
  // the reset bit is not stored, so it always reads back as zero
  // lanes merge one at a time, so a partial-strobe write keeps the rest
  wire [7:0] cnt_lo_nxt = wr_cnt_lo ? wd[7:0] : cnt_ctrl_r[7:0];
  wire [7:0] cnt_hi_nxt = wr_cnt_hi ? wd[15:8] : cnt_ctrl_r[15:8];
  // reserved bits and the reset bit are masked here and read as zero
  wire [`CNT_CTRL_W-1:0] cnt_ctrl_nxt =
    {cnt_hi_nxt, cnt_lo_nxt} & `CNT_CTRL_MASK;
  wire [`CLK_CTRL_W-1:0] clk_ctrl_nxt = wr_clk ? wd[7:0] : clk_ctrl_r;
  // the pulse lasts one cycle: it is rebuilt from the write strobe each time
  wire crst_nxt = wr_cnt_lo && wd[`CRST_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_ctrl_r <= `CLK_CTRL_RST;
      cnt_ctrl_r <= `CNT_CTRL_RST;
      crst_r <= 1'b0;
    end else if (ce) begin
      clk_ctrl_r <= clk_ctrl_nxt;
      cnt_ctrl_r <= cnt_ctrl_nxt;
      crst_r <= crst_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel, one cycle after the address is taken
  wire [1:0] rsel = reg_sel(s_axi_araddr);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  // unmapped addresses read as zero with an error response
  wire [31:0] rd_word = rsel[0] ? 32'(clk_ctrl_r) :
                        rsel[1] ? 32'(cnt_ctrl_r) : 32'h0000_0000;
  wire [1:0] rd_resp = (rsel == 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
  // arready stays low while data waits, so one read at a time
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_resp;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // count clock path
  wire [1:0] src_sel = clk_ctrl_r[`SRC_LSB+1:`SRC_LSB];
  wire [3:0] div_raw = clk_ctrl_r[`DIV_LSB+3:`DIV_LSB];
  // code 0xf unused; the limited source group stops at 1/256
  // the source limit applies after the clamp, so 0xf there ends at 1/256
  wire [3:0] div_cap = (div_raw > `DIV_MAX) ? `DIV_MAX : div_raw;
  wire [3:0] div_eff = (src_sel == `SRC_LIMITED && div_cap > `DIV_LIMITED)
                       ? `DIV_LIMITED : div_cap;
  wire clk_en = clk_ctrl_r[`COUNT_CLOCK_ENABLE_BIT];
  logic div_tick;

  // the divider only advances on ticks of the selected source; clearing
  // the enable clears its prescaler, so a restart begins a fresh period
  // rather than resuming one that was cut short
  count_clock_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(clk_en),
    .src_tick(src_tick[src_sel]),
    .div_sel(div_eff),
    .tick(div_tick)
  );

  // the registered tick is gated again so that it stops in the very cycle
  // the enable bit clears, not one cycle later
  assign count_tick = div_tick && clk_en;
  assign counter_run = cnt_ctrl_r[`RUN_BIT];
  assign counter_reset_pulse = crst_r;
  assign one_shot_repeat_select = cnt_ctrl_r[`ONESHOT_BIT];
  assign compare_buffer_enable = cnt_ctrl_r[`CBUF_BIT];
  assign multi_compare_capture_mode = clk_ctrl_r[`MULTI_BIT];
  assign counter_channel_select = cnt_ctrl_r[`CHSEL_LSB+1:`CHSEL_LSB];
  assign count_clock_source_select = src_sel;
endmodule

// ### pwm_timer_defines.svh
// Purpose: constants for the pwm timer channel control block
// Assumes: 32-bit axi4-lite data, one register per aligned word
// Notes: byte addresses equal the printed offsets
`ifndef PWM_TIMER_DEFINES_SVH
`define PWM_TIMER_DEFINES_SVH
`define ADDR_W 16
`define CLK_CTRL_ADDR 16'h5068
`define CNT_CTRL_ADDR 16'h5400
`define CLK_CTRL_W 8
`define CNT_CTRL_W 16
`define CLK_CTRL_RST 8'h00
`define CNT_CTRL_RST 16'h0000
`define COUNT_CLOCK_ENABLE_BIT 0
`define MULTI_BIT 1
`define SRC_LSB 2
`define DIV_LSB 4
`define RUN_BIT 0
`define CRST_BIT 1
`define ONESHOT_BIT 2
`define CBUF_BIT 3
`define CHSEL_LSB 4
`define DIV_MAX 4'he
`define DIV_LIMITED 4'h8
`define SRC_LIMITED 2'h2
`define CNT_CTRL_MASK 16'h003d
`define PRE_W 14
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### pwm_timer_pkg.sv
// Purpose: types for the pwm timer channel control block
// Assumes: nothing beyond the defines header
// Notes: write handshake states
package pwm_timer_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
endpackage

// ### count_clock_divider.sv
// Purpose: power-of-two prescaler for the count clock
// Assumes: src_tick is a one-cycle pulse per source clock period
// Notes: emits one tick per 2^div_sel source ticks
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"
module count_clock_divider (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic enable, // count clock enable
  input wire logic src_tick, // source clock tick
  input wire logic [3:0] div_sel, // division code
  output logic tick // divided count tick
);
  logic [`PRE_W-1:0] pre_r;
  logic [`PRE_W-1:0] mask;
  logic hit;
  // code n divides by 2^n; mask low n bits of the prescaler
  assign mask = `PRE_W'((`PRE_W+1)'(1) << div_sel) - `PRE_W'(1);
  assign hit = src_tick && ((pre_r & mask) == mask);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        pre_r <= '0;
        tick <= 1'b0;
      end else begin
        if (src_tick) begin
          pre_r <= pre_r + `PRE_W'(1);
        end
        tick <= hit;
      end
    end
  end
endmodule

// ### pwm_timer_channel_control_assertions.sv
// Purpose: port checks for the pwm timer channel control block
// Assumes: ce held high, one clock domain
// Notes: run, count mode and buffer enable changes are tied to the write response that causes them
`timescale 1ns/100ps
module pwm_timer_checker (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [3:0] src_tick, // source ticks
  input wire logic s_axi_bvalid, // write response valid
  input wire logic count_tick, // gated count tick
  input wire logic counter_run, // run level
  input wire logic counter_reset_pulse, // counter reset pulse
  input wire logic one_shot_repeat_select, // count mode
  input wire logic compare_buffer_enable, // compare buffering
  input wire logic [1:0] count_clock_source_select // source select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  property p_tick_src;
    count_tick |-> $past(src_tick[count_clock_source_select]);
  endproperty
  a_tick_src: assert property (p_tick_src)
    else $error("count tick without source tick");
  property p_buf;
    $changed(compare_buffer_enable) |-> $rose(s_axi_bvalid);
  endproperty
  a_buf: assert property (p_buf)
    else $error("buffer enable changed without write");
  property p_mode;
    $changed(one_shot_repeat_select) |-> $rose(s_axi_bvalid);
  endproperty
  a_mode: assert property (p_mode)
    else $error("count mode changed without write");
  property p_run;
    $changed(counter_run) |-> $rose(s_axi_bvalid);
  endproperty
  a_run: assert property (p_run)
    else $error("run changed without write");
  property p_pulse;
    counter_reset_pulse |-> $rose(s_axi_bvalid) ##1 !counter_reset_pulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("counter reset pulse malformed");
  property p_rst_val;
    $rose(aresetn) |-> !(counter_run | counter_reset_pulse | count_tick
      | one_shot_repeat_select | compare_buffer_enable);
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("output not zero after reset");
endmodule
bind pwm_timer_channel_control pwm_timer_checker chk_u (.aclk(aclk),
  .aresetn(aresetn), .src_tick(src_tick), .s_axi_bvalid(s_axi_bvalid),
  .count_tick(count_tick), .counter_run(counter_run),
  .counter_reset_pulse(counter_reset_pulse),
  .one_shot_repeat_select(one_shot_repeat_select),
  .compare_buffer_enable(compare_buffer_enable),
  .count_clock_source_select(count_clock_source_select));

// ### tb_pwm_timer_channel_control.sv
// Purpose: self-checking bench for the pwm timer channel control block
// Assumes: sources 0 and 1 tick each cycle, sources 2 and 3 every other
// Notes: divider windows start after one warm-up period to skip phase
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %0h not %0h", $time, a, b); end end
module tb_pwm_timer_channel_control;
  import pwm_timer_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [3:0] src_tick = 4'hf, s_axi_wstrb = 4'hf;
  logic pulse;
  logic [`ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, count_tick, counter_run;
  logic counter_reset_pulse, one_shot_repeat_select, compare_buffer_enable;
  logic multi_compare_capture_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, counter_channel_select, r;
  logic [1:0] count_clock_source_select;
  int errors = 0, checked = 0, n;
  always #50 aclk = ~aclk;
  // slower sources make the source select and the tick check matter
  always @(posedge aclk) src_tick[3:2] <= ~src_tick[3:2];
  pwm_timer_channel_control dut_u (.aclk, .aresetn, .ce, .src_tick,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .count_tick, .counter_run,
    .counter_reset_pulse, .one_shot_repeat_select, .compare_buffer_enable,
    .multi_compare_capture_mode, .counter_channel_select,
    .count_clock_source_select);
  //////////////////////////////////////////////////////////////////////////
  // handshakes are judged at the negedge, where combinational readys settle
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic ta, tw, aw, w, t;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      aw = aw | ta;
      w = w | tw;
    end
    do begin
      @(negedge aclk);
      t = s_axi_bvalid;
      r = s_axi_bresp;
      pulse = counter_reset_pulse;
      @(posedge aclk);
    end while (!t);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [15:0] a);
    logic t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task automatic t_regs;
    rd(`CLK_CTRL_ADDR);
    `CHK(d, 32'h0000_0000)
    rd(16'h5000);
    `CHK({r, d}, {`RESP_SLVERR, 32'h0000_0000})
    wr(`CNT_CTRL_ADDR, 32'hffff_ffff);
    `CHK(pulse, 1'b1)
    `CHK({counter_channel_select, compare_buffer_enable}, 3'h7)
    `CHK({one_shot_repeat_select, counter_run}, 2'h3)
    rd(`CNT_CTRL_ADDR);
    `CHK(d, 32'h0000_003d)
    wr(`CNT_CTRL_ADDR, 32'h0000_0000);
    `CHK(pulse, 1'b0)
    `CHK({compare_buffer_enable, one_shot_repeat_select}, 2'h0)
    `CHK(counter_run, 1'b0)
  endtask
  // one warm-up period, then two periods must hold exactly two ticks
  // p is the expected tick period in aclk cycles
  task automatic t_div(input logic [3:0] c, input logic [1:0] s, input int p);
    logic [2:0] sel;
    wr(`CLK_CTRL_ADDR, {24'h00_0000, c, s, 2'b11});
    sel = {multi_compare_capture_mode, count_clock_source_select};
    `CHK(sel, {1'b1, s})
    repeat (p) @(posedge aclk);
    n = 0;
    repeat (2 * p) begin
      @(negedge aclk);
      n += count_tick;
    end
    `CHK(n, 2)
    wr(`CLK_CTRL_ADDR, {24'h00_0000, c, s, 2'b10});
    n = 0;
    repeat (p) begin
      @(negedge aclk);
      n += count_tick;
    end
    `CHK(n, 0)
    @(posedge aclk);
  endtask
  task automatic complete_run;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #9_500_000;
    errors++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs;
    t_div(4'h0, 2'h0, 1);
    t_div(4'h1, 2'h0, 2);
    t_div(4'h5, 2'h0, 32);
    t_div(4'he, 2'h0, 16384);
    t_div(4'h1, 2'h3, 4);
    t_div(4'h2, 2'h2, 8);
    t_div(4'he, 2'h2, 512);
    t_div(4'hf, 2'h2, 512);
    complete_run;
  end
endmodule
